// ### hw/dsrs_top.v
// Dual supply reset supervisor core with Avalon-MM register slave
//
// Functional notes
// - select pin high, open, low sets polarities
// - negative input valid only below trip
// - positive input valid only above trip
// - release only after all valid whole timeout
// - lockout release samples select, initialises timer
// - invalid after start-up holds reset, no timing
// - lockout or invalid input asserts reset immediately
// - recovery starts timer; reset held until done
// - invalid during timeout restarts from zero
// - external, internal, or no timeout
// - one threshold; hysteresis only comparator mode
// - comparator results filtered before output logic
// - timer control low selects internal timeout
// - timer control high bypasses timer entirely
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "dsrs_regs.vh"
module dsrs_top #(
  parameter CYC_PER_MS = `DSRS_CLK_MHZ * 1000,
  parameter FILT_CYC = `DSRS_FILT_NS * `DSRS_CLK_MHZ / 1000,
  parameter TICK_W = 18,
  parameter FILT_W = 14,
  parameter TO_W = 16
) (
  input wire clk, // 200 MHz system clock
  input wire sys_rst, // Synchronous reset, active high
  input wire mon_one_above, // Input one comparator: above trip
  input wire mon_two_above, // Input two comparator: above trip
  input wire supply_ok, // Supply above lockout threshold
  input wire sel_high, // Select pin sensed high
  input wire sel_low, // Select pin sensed low
  input wire tmr_high, // Timeout control tied to supply
  input wire tmr_low, // Timeout control tied low
  input wire [4:0] avs_address, // Byte address
  input wire avs_read, // Read request
  input wire avs_write, // Write request
  input wire [31:0] avs_writedata, // Write data
  input wire [3:0] avs_byteenable, // Byte lanes
  output reg [31:0] avs_readdata, // Read data
  output reg avs_waitrequest, // Stall until answered
  output reg irq, // Level interrupt
  output reg rst_n_o, // Reset pin output level, always low
  output reg rst_n_oe, // Reset pin pulled low while high
  output reg hyst_one_en, // Shift input one threshold
  output reg hyst_two_en // Shift input two threshold
);

////////////////////////////////////////////////////////////////////////////////
// Local definitions

localparam ST_LOCK = 2'h0;
localparam ST_WAIT = 2'h1;
localparam ST_TIME = 2'h2;
localparam ST_RUN = 2'h3;

// Validity from comparator side and polarity, used for both inputs
function valid_of;
  input above;
  input neg;
  begin
    valid_of = neg ? ~above : above;
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

reg [6:0] sync1_reg;
reg [6:0] sync2_reg;

// Every pin is asynchronous; first stage feeds only the second
always @(posedge clk) begin
  if (sys_rst) begin
    sync1_reg <= 7'h00;
    sync2_reg <= 7'h00;
  end else begin
    sync1_reg <= {tmr_low, tmr_high, sel_low, sel_high, supply_ok, mon_two_above, mon_one_above};
    sync2_reg <= sync1_reg;
  end
end

wire s_sel_high = sync2_reg[3];
wire s_sel_low = sync2_reg[4];
wire s_tmr_high = sync2_reg[5];
wire s_tmr_low = sync2_reg[6];

////////////////////////////////////////////////////////////////////////////////
// Comparator filters

wire f_one_above;
wire f_two_above;
wire f_supply;

dsrs_filt #(.W(FILT_W), .LEN(FILT_CYC)) u_filt_one (
  .clk(clk), .sys_rst(sys_rst), .din(sync2_reg[0]), .dout(f_one_above)
);

dsrs_filt #(.W(FILT_W), .LEN(FILT_CYC)) u_filt_two (
  .clk(clk), .sys_rst(sys_rst), .din(sync2_reg[1]), .dout(f_two_above)
);

dsrs_filt #(.W(FILT_W), .LEN(FILT_CYC)) u_filt_sup (
  .clk(clk), .sys_rst(sys_rst), .din(sync2_reg[2]), .dout(f_supply)
);

////////////////////////////////////////////////////////////////////////////////
// Start-up configuration

reg pol1_neg_reg;
reg pol2_neg_reg;
reg [1:0] mode_reg;
reg [1:0] state_reg;
reg [1:0] state_next;

// sample select and timer mode on lockout release
// neither level sensed means the pin floats
always @(posedge clk) begin
  if (sys_rst) begin
    pol1_neg_reg <= 1'b0;
    pol2_neg_reg <= 1'b0;
    mode_reg <= `DSRS_MODE_EXT;
  end else if (state_reg == ST_LOCK && f_supply) begin
    // high both positive, open mixed, low both negative
    pol1_neg_reg <= s_sel_low & ~s_sel_high;
    pol2_neg_reg <= ~s_sel_high;
    if (s_tmr_high) begin
      mode_reg <= `DSRS_MODE_CMP;
    end else if (s_tmr_low) begin
      mode_reg <= `DSRS_MODE_INT;
    end else begin
      mode_reg <= `DSRS_MODE_EXT;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Validity

wire valid1 = valid_of(f_one_above, pol1_neg_reg);
wire valid2 = valid_of(f_two_above, pol2_neg_reg);
wire all_valid = valid1 & valid2 & f_supply;

////////////////////////////////////////////////////////////////////////////////
// Timeout counter

reg [TO_W-1:0] ext_to_reg;
reg [TO_W-1:0] ms_cnt_reg;
wire ms_tick;
wire timer_start = (state_next == ST_TIME) && (state_reg != ST_TIME);
// A zero external setting still waits one full millisecond
wire [TO_W-1:0] to_term = (mode_reg == `DSRS_MODE_INT) ? `DSRS_INT_TIMEOUT_MS :
  ((ext_to_reg == {TO_W{1'b0}}) ? {{(TO_W-1){1'b0}}, 1'b1} : ext_to_reg);
wire timer_done = ms_tick && (ms_cnt_reg == to_term - 1'b1);

dsrs_tick #(.W(TICK_W), .DIV(CYC_PER_MS)) u_tick (
  .clk(clk), .sys_rst(sys_rst), .restart(timer_start), .tick(ms_tick)
);

always @(posedge clk) begin
  if (sys_rst || timer_start) begin
    ms_cnt_reg <= {TO_W{1'b0}};
  end else if (state_reg == ST_TIME && ms_tick) begin
    ms_cnt_reg <= ms_cnt_reg + 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Sequencer

// Next state; lockout dominates everything else
always @* begin
  state_next = state_reg;
  case (state_reg)
    ST_LOCK: begin
      if (f_supply) begin
        state_next = ST_WAIT;
      end
    end
    ST_WAIT: begin
      // no timing until all three are valid
      if (!f_supply) begin
        state_next = ST_LOCK;
      end else if (all_valid) begin
        state_next = (mode_reg == `DSRS_MODE_CMP) ? ST_RUN : ST_TIME;
      end
    end
    ST_TIME: begin
      // abandon count on any invalid excursion
      if (!f_supply) begin
        state_next = ST_LOCK;
      end else if (!all_valid) begin
        state_next = ST_WAIT;
      end else if (timer_done) begin
        // released only after the full timeout
        state_next = ST_RUN;
      end
    end
    ST_RUN: begin
      // loss of validity on any input asserts reset
      if (!f_supply) begin
        state_next = ST_LOCK;
      end else if (!all_valid) begin
        state_next = ST_WAIT;
      end
    end
    default: begin
      state_next = ST_LOCK;
    end
  endcase
end

always @(posedge clk) begin
  if (sys_rst) begin
    state_reg <= ST_LOCK;
  end else begin
    state_reg <= state_next;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Output pins

// reset held low until the timer is done, or until all valid in comparator mode
// threshold shift only in comparator mode, while invalid
always @(posedge clk) begin
  if (sys_rst) begin
    rst_n_o <= 1'b0;
    rst_n_oe <= 1'b1;
    hyst_one_en <= 1'b0;
    hyst_two_en <= 1'b0;
  end else begin
    rst_n_o <= 1'b0;
    rst_n_oe <= (state_next != ST_RUN);
    hyst_one_en <= (mode_reg == `DSRS_MODE_CMP) && !valid1;
    hyst_two_en <= (mode_reg == `DSRS_MODE_CMP) && !valid2;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt events

reg valid1_d_reg;
reg valid2_d_reg;
reg supply_d_reg;
reg run_d_reg;
reg [`DSRS_IRQ_W-1:0] irq_st_reg;
reg [`DSRS_IRQ_W-1:0] irq_mask_reg;
reg [`DSRS_IRQ_W-1:0] ev;
wire run_now = (state_reg == ST_RUN);
wire st_read_clr;

// Edge history for event detection
always @(posedge clk) begin
  if (sys_rst) begin
    valid1_d_reg <= 1'b0;
    valid2_d_reg <= 1'b0;
    supply_d_reg <= 1'b0;
    run_d_reg <= 1'b0;
  end else begin
    valid1_d_reg <= valid1;
    valid2_d_reg <= valid2;
    supply_d_reg <= f_supply;
    run_d_reg <= run_now;
  end
end

// Event pulses of one cycle each
always @* begin
  ev = {`DSRS_IRQ_W{1'b0}};
  ev[`DSRS_IRQ_ASSERT] = run_d_reg & ~run_now;
  ev[`DSRS_IRQ_RELEASE] = ~run_d_reg & run_now;
  ev[`DSRS_IRQ_INV1] = valid1_d_reg & ~valid1;
  ev[`DSRS_IRQ_INV2] = valid2_d_reg & ~valid2;
  ev[`DSRS_IRQ_LOCK] = supply_d_reg & ~f_supply;
end

// Sticky bits; a read clears only what it showed, so a late event survives
always @(posedge clk) begin
  if (sys_rst) begin
    irq_st_reg <= {`DSRS_IRQ_W{1'b0}};
    irq <= 1'b0;
  end else begin
    irq_st_reg <= (st_read_clr ? irq_st_reg & ~avs_readdata[`DSRS_IRQ_W-1:0] : irq_st_reg) | ev;
    irq <= |(irq_st_reg & irq_mask_reg);
  end
end

////////////////////////////////////////////////////////////////////////////////
// Avalon-MM slave

// Request is completed at the edge where waitrequest is seen low
wire acc = !avs_waitrequest && (avs_read || avs_write);
wire wr_acc = acc && avs_write;
assign st_read_clr = acc && avs_read && (avs_address == `DSRS_OFF_IRQ_ST);

// One wait cycle per access, then waitrequest rises again
always @(posedge clk) begin
  if (sys_rst) begin
    avs_waitrequest <= 1'b1;
  end else if (acc) begin
    avs_waitrequest <= 1'b1;
  end else if (avs_read || avs_write) begin
    avs_waitrequest <= 1'b0;
  end
end

// Read data built while the answer is prepared; unmapped reads zero
always @(posedge clk) begin
  if (sys_rst) begin
    avs_readdata <= 32'h00000000;
  end else if (avs_read && avs_waitrequest) begin
    avs_readdata <= 32'h00000000;
    case (avs_address)
      `DSRS_OFF_STATUS: begin
        avs_readdata[`DSRS_ST_RST] <= rst_n_oe;
        avs_readdata[`DSRS_ST_VALID1] <= valid1;
        avs_readdata[`DSRS_ST_VALID2] <= valid2;
        avs_readdata[`DSRS_ST_SUPPLY] <= f_supply;
        avs_readdata[`DSRS_ST_STATE_HI:`DSRS_ST_STATE_LO] <= state_reg;
        avs_readdata[`DSRS_ST_MODE_HI:`DSRS_ST_MODE_LO] <= mode_reg;
        avs_readdata[`DSRS_ST_POL1] <= pol1_neg_reg;
        avs_readdata[`DSRS_ST_POL2] <= pol2_neg_reg;
      end
      `DSRS_OFF_IRQ_ST: avs_readdata[`DSRS_IRQ_W-1:0] <= irq_st_reg;
      `DSRS_OFF_IRQ_MASK: avs_readdata[`DSRS_IRQ_W-1:0] <= irq_mask_reg;
      `DSRS_OFF_EXT_TO: avs_readdata[TO_W-1:0] <= ext_to_reg;
      default: avs_readdata <= 32'h00000000;
    endcase
  end
end

// Writable registers honour byte lanes; other offsets ignore writes
always @(posedge clk) begin
  if (sys_rst) begin
    irq_mask_reg <= `DSRS_RST_IRQ_MASK;
    ext_to_reg <= `DSRS_RST_EXT_TO;
  end else if (wr_acc) begin
    if (avs_address == `DSRS_OFF_IRQ_MASK && avs_byteenable[0]) begin
      irq_mask_reg <= avs_writedata[`DSRS_IRQ_W-1:0];
    end
    // software sets the external duration in ms
    if (avs_address == `DSRS_OFF_EXT_TO) begin
      if (avs_byteenable[0]) begin
        ext_to_reg[7:0] <= avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        ext_to_reg[15:8] <= avs_writedata[15:8];
      end
    end
  end
end

endmodule

// ### hw/dsrs_regs.vh
// Register map, field layout, reset values and timing constants of the supervisor
`ifndef DSRS_REGS_VH
`define DSRS_REGS_VH

// Register byte offsets
`define DSRS_OFF_STATUS 5'h00
`define DSRS_OFF_IRQ_ST 5'h04
`define DSRS_OFF_IRQ_MASK 5'h08
`define DSRS_OFF_EXT_TO 5'h0C

// Status register fields
`define DSRS_ST_RST 0
`define DSRS_ST_VALID1 1
`define DSRS_ST_VALID2 2
`define DSRS_ST_SUPPLY 3
`define DSRS_ST_STATE_LO 4
`define DSRS_ST_STATE_HI 5
`define DSRS_ST_MODE_LO 6
`define DSRS_ST_MODE_HI 7
`define DSRS_ST_POL1 8
`define DSRS_ST_POL2 9

// Interrupt status and mask fields
`define DSRS_IRQ_W 5
`define DSRS_IRQ_ASSERT 0
`define DSRS_IRQ_RELEASE 1
`define DSRS_IRQ_INV1 2
`define DSRS_IRQ_INV2 3
`define DSRS_IRQ_LOCK 4

// Reset values
`define DSRS_RST_IRQ_MASK 5'h00
`define DSRS_RST_EXT_TO 16'h0014

// Timer modes
`define DSRS_MODE_EXT 2'h0
`define DSRS_MODE_INT 2'h1
`define DSRS_MODE_CMP 2'h2

// Timing: clock rate, internal timeout, comparator filter time
`define DSRS_CLK_MHZ 200
`define DSRS_INT_TIMEOUT_MS 16'h00C8
`define DSRS_FILT_NS 50000

`endif

// ### hw/dsrs_filt.v
// Glitch filter: output follows input only after a stable run of LEN cycles
`timescale 1ns/10ps
module dsrs_filt #(
  parameter W = 14,
  parameter LEN = 10000
) (
  input wire clk, // System clock
  input wire sys_rst, // Synchronous reset, active high
  input wire din, // Synchronised comparator result
  output reg dout // Filtered result
);

reg [W-1:0] cnt_reg;

// Count while input disagrees; any agreement restarts the run
always @(posedge clk) begin
  if (sys_rst) begin
    cnt_reg <= {W{1'b0}};
    dout <= 1'b0;
  end else if (din == dout) begin
    cnt_reg <= {W{1'b0}};
  end else if (cnt_reg == LEN[W-1:0] - 1'b1) begin
    cnt_reg <= {W{1'b0}};
    dout <= din;
  end else begin
    cnt_reg <= cnt_reg + 1'b1;
  end
end

endmodule

// ### hw/dsrs_tick.v
// Divider giving a one-cycle enable every DIV clocks, restartable
`timescale 1ns/10ps
module dsrs_tick #(
  parameter W = 18,
  parameter DIV = 200000
) (
  input wire clk, // System clock
  input wire sys_rst, // Synchronous reset, active high
  input wire restart, // Begin a fresh full period
  output reg tick // One-cycle enable pulse
);

reg [W-1:0] cnt_reg;

// Restart keeps the first period of a timeout full length
always @(posedge clk) begin
  if (sys_rst || restart) begin
    cnt_reg <= {W{1'b0}};
    tick <= 1'b0;
  end else if (cnt_reg == DIV[W-1:0] - 1'b1) begin
    cnt_reg <= {W{1'b0}};
    tick <= 1'b1;
  end else begin
    cnt_reg <= cnt_reg + 1'b1;
    tick <= 1'b0;
  end
end

endmodule

// ### test/dsrs_sys_model.sv
// Far-side system logic: reset pull-up and select pin driver
`timescale 1ns/10ps
module dsrs_sys_model (
  input wire rst_n_o, // Pin data
  input wire rst_n_oe, // Block pulls pin
  input wire sel_oe, // Select buffer on
  input wire sel_val, // Select level
  output wire rst_pin, // Resolved reset wire
  output wire sel_high, // Sensed high
  output wire sel_low // Sensed low
);
  // Pull-up wins once the block lets go
  assign rst_pin = rst_n_oe ? rst_n_o : 1'b1;
  // tied or floated select
  // A released buffer reads as open, never a stale level
  assign sel_high = sel_oe & sel_val;
  assign sel_low = sel_oe & ~sel_val;
endmodule

// ### test/dsrs_top_properties.sv
// Port-level checks of the supervisor top
`timescale 1ns/10ps
module dsrs_top_chk #(
  parameter FILT_CYC = 4
) (
  input wire clk, // Clock
  input wire sys_rst, // Reset
  input wire supply_ok, // Supply flag
  input wire [4:0] avs_address, // Address
  input wire avs_read, // Read
  input wire avs_write, // Write
  input wire [31:0] avs_writedata, // Data
  input wire [31:0] avs_readdata, // Read data
  input wire avs_waitrequest, // Stall
  input wire irq, // Interrupt
  input wire rst_n_o, // Pin data
  input wire rst_n_oe, // Pin pulled
  input wire hyst_one_en, // Shift one
  input wire hyst_two_en // Shift two
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // Run length of a low supply flag, saturating
  reg [15:0] low_cnt_reg;
  always @(posedge clk) begin
    if (sys_rst || supply_ok) begin
      low_cnt_reg <= 16'h0000;
    end else if (low_cnt_reg != 16'hFFFF) begin
      low_cnt_reg <= low_cnt_reg + 16'h0001;
    end
  end
  // Bus steps
  sequence s_req_new;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_mask_zero;
    avs_write && !avs_waitrequest && avs_address == 5'h08 && avs_writedata[4:0] == 5'h00;
  endsequence
  ////////////////////////////////////////
  a_reset_holds: assert property (disable iff (1'b0)
    sys_rst |=> rst_n_oe && !irq && avs_waitrequest && !hyst_one_en && !hyst_two_en)
    else $error("outputs not at reset level");
  a_pin_data_low: assert property (rst_n_o == 1'b0)
    else $error("reset pin data not low");
  a_supply_loss: assert property (low_cnt_reg >= FILT_CYC + 6 |-> rst_n_oe)
    else $error("reset free with supply low");
  a_release_cause: assert property (
    $fell(rst_n_oe) |-> $past(supply_ok) && $past(supply_ok, FILT_CYC))
    else $error("reset released without supply");
  a_hyst_only_bad: assert property ((hyst_one_en || hyst_two_en) |-> ##[0:2] rst_n_oe)
    else $error("hysteresis with reset free");
  a_wait_one: assert property (s_req_new |=> !avs_waitrequest)
    else $error("no answer after one wait");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_rdata_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("readdata moved without read");
  a_mask_clear: assert property (s_mask_zero |-> ##[1:3] !irq)
    else $error("irq high with mask clear");
endmodule
bind dsrs_top dsrs_top_chk #(.FILT_CYC(FILT_CYC)) dsrs_top_chk_inst (
  .clk(clk),
  .sys_rst(sys_rst),
  .supply_ok(supply_ok),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .irq(irq),
  .rst_n_o(rst_n_o),
  .rst_n_oe(rst_n_oe),
  .hyst_one_en(hyst_one_en),
  .hyst_two_en(hyst_two_en)
);

// ### test/dsrs_top_tb_top.sv
// Self-checking bench for the supply supervisor
`timescale 1ns/10ps
module dsrs_top_tb_top;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg m1 = 1'b0;
  reg m2 = 1'b0;
  reg sup = 1'b0;
  reg tmh = 1'b1;
  reg tml = 1'b0;
  reg sel_oe = 1'b1;
  reg sel_val = 1'b1;
  reg [4:0] addr = 5'h00;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wd = 32'h00000000;
  reg [3:0] be = 4'hF;
  reg pend = 1'b0;
  reg [31:0] seed = 32'h20FABC7E;
  reg [1:0] pol;
  reg [63:0] ev;
  reg [7:0] pv;
  reg [63:0] eq[$];
  reg [7:0] pq[$];
  integer err_total = 0;
  integer checked = 0;
  integer t;
  wire [31:0] rdata;
  wire wreq, irq, rst_n_o, rst_n_oe, h1, h2, rst_pin, sel_high, sel_low;
  ////////////////////////////////////////
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // Short counts keep the run brief
  dsrs_top #(.CYC_PER_MS(10), .FILT_CYC(4)) dsrs_top_inst (
    .clk(clk), .sys_rst(sys_rst), .mon_one_above(m1), .mon_two_above(m2),
    .supply_ok(sup), .sel_high(sel_high), .sel_low(sel_low), .tmr_high(tmh),
    .tmr_low(tml), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .irq(irq), .rst_n_o(rst_n_o), .rst_n_oe(rst_n_oe),
    .hyst_one_en(h1), .hyst_two_en(h2));
  dsrs_sys_model dsrs_sys_model_inst (.rst_n_o(rst_n_o), .rst_n_oe(rst_n_oe),
    .sel_oe(sel_oe), .sel_val(sel_val), .rst_pin(rst_pin), .sel_high(sel_high),
    .sel_low(sel_low));
  ////////////////////////////////////////
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task cmp(input [31:0] g, input [31:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // One bus cycle; a read notes its masked expectation
  task bus(input r, input [4:0] a, input [31:0] d, input [3:0] b, input [31:0] m,
    input [31:0] e);
    begin
      if (r) begin
        eq.push_back({m, e});
      end
      @(posedge clk);
      rd <= r;
      wr <= !r;
      addr <= a;
      wd <= d;
      be <= b;
      @(posedge clk);
      // Only the watchdog ends a wait that never sees an answer
      while (wreq !== 1'b0) begin
        @(posedge clk);
      end
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  // Notes expected {h1, h2, irq, pin} for the next edge
  task look(input [3:0] m, input [3:0] e);
    begin
      @(posedge clk);
      pq.push_back({m, e});
      pend <= 1'b1;
      @(posedge clk);
      pend <= 1'b0;
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task drive(input s, input a, input b);
    begin
      @(posedge clk);
      sup <= s;
      m1 <= a;
      m2 <= b;
    end
  endtask
  // Lockout, then pins, then supply up: select 0 high 1 open 2 low
  task boot(input [1:0] sel, input [1:0] md, input a, input b);
    begin
      drive(1'b0, a, b);
      wt(15);
      sel_oe <= sel != 2'd1;
      sel_val <= sel == 2'd0;
      tml <= md == 2'd1;
      tmh <= md == 2'd2;
      drive(1'b1, a, b);
    end
  endtask
  task results;
    begin
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  // Output watcher: oldest note against what appears
  always @(posedge clk) begin
    if (rd && wreq === 1'b0) begin
      ev = eq.pop_front();
      cmp(rdata & ev[63:32], ev[31:0]);
    end
    if (pend) begin
      pv = pq.pop_front();
      cmp({28'h0, {h1, h2, irq, rst_pin} & pv[7:4]}, {28'h0, pv[3:0]});
    end
  end
  // Hang guard
  initial begin
    #200000;
    err_total = err_total + 1;
    results;
  end
  // Main sequence
  initial begin
    wt(12);
    sys_rst <= 1'b0;
    look(3'b001, 3'b000); // held in lockout
    bus(1, 5'h08, 0, 4'hF, 32'h1F, 0);
    bus(1, 5'h0C, 0, 4'hF, 32'hFFFF, 32'h14);
    bus(1, 5'h10, 0, 4'hF, 32'hFFFFFFFF, 0);
    bus(0, 5'h00, 32'hFFFFFFFF, 4'hF, 0, 0);
    bus(1, 5'h00, 0, 4'hF, 32'h1, 32'h1);
    $display("test 1 done");
    for (t = 0; t < 3; t = t + 1) begin
      pol = (t == 0) ? 2'b00 : ((t == 1) ? 2'b10 : 2'b11);
      boot(t[1:0], 2'd2, !pol[0], !pol[1]);
      wt(14);
      look(3'b101, 3'b001); // follows validity
      bus(1, 0, 0, 4'hF, 32'h3FF, {22'h0, pol, 8'hBE}); // polarity seen
      drive(1'b1, !pol[0], pol[1]);
      wt(14);
      look(4'b1101, 4'b0100); // invalid asserts
      drive(1'b1, pol[0], !pol[1]);
      wt(14);
      look(4'b1101, 4'b1000); // input one shifted
      drive(1'b1, !pol[0], !pol[1]);
      wt(14);
      seed = lfsr(seed);
      drive(1'b1, pol[0], !pol[1]);
      wt(seed % 3);
      drive(1'b1, !pol[0], !pol[1]);
      wt(14);
      look(3'b001, 3'b001); // glitch ignored
    end
    $display("test 2 done");
    boot(2'd0, 2'd1, 1'b1, 1'b1);
    wt(1990);
    look(3'b101, 3'b000); // still timing
    wt(30);
    look(3'b001, 3'b001); // released
    drive(1'b1, 1'b1, 1'b0);
    wt(14);
    look(3'b101, 3'b000); // no shift timed
    $display("test 3 done");
    seed = lfsr(seed);
    t = 3 + seed % 4;
    bus(0, 5'h0C, t, 4'h3, 0, 0);
    bus(1, 5'h0C, 0, 4'hF, 32'hFFFF, t);
    boot(2'd0, 2'd0, 1'b0, 1'b1);
    wt(t * 10 + 30);
    look(3'b001, 3'b000); // waits for valid
    drive(1'b1, 1'b1, 1'b1);
    wt(t * 5);
    drive(1'b1, 1'b0, 1'b1);
    wt(10);
    drive(1'b1, 1'b1, 1'b1);
    wt(t * 10 - 5);
    look(3'b001, 3'b000); // count restarted
    wt(25);
    look(3'b001, 3'b001); // released after timer
    $display("test 4 done");
    // interrupt on lockout, clear and mask
    bus(1, 5'h04, 0, 4'hF, 0, 0);
    bus(0, 5'h08, 32'h1F, 4'h1, 0, 0);
    drive(1'b0, 1'b1, 1'b1);
    wt(14);
    look(3'b011, 3'b010); // irq and pin low
    bus(1, 5'h04, 0, 4'hF, 32'h11, 32'h11); // events logged
    wt(3);
    look(3'b010, 3'b000);
    drive(1'b1, 1'b1, 1'b1);
    wt(14);
    drive(1'b0, 1'b1, 1'b1);
    wt(14);
    bus(0, 5'h08, 0, 4'h1, 0, 0);
    wt(3);
    look(3'b010, 3'b000);
    $display("test 5 done");
    results;
  end
endmodule
